// [bsr_pkg.sv]
// Package for the backup state retention block: register layouts, reset values, types
package bsr_pkg;

  // ==========================================================
  // Register map (word offsets are byte addresses)
  // ==========================================================
  localparam logic [5:0] OFF_CLOCK_CTRL = 6'h00; // Clock control
  localparam logic [5:0] OFF_EXT_IRQ_A = 6'h04; // External interrupt control A
  localparam logic [5:0] OFF_EXT_IRQ_B = 6'h08; // External interrupt control B
  localparam logic [5:0] OFF_OSC_SEL = 6'h0C; // Oscillator selection
  localparam logic [5:0] OFF_PRESCALER = 6'h10; // Prescaler control
  localparam logic [5:0] OFF_TIMER_BASE = 6'h14; // Timer controls one..six at 0x14..0x28
  localparam logic [5:0] OFF_SERIAL_MODE = 6'h2C; // Serial mode
  localparam logic [5:0] OFF_CONV_BASE = 6'h30; // Converter controls first..third
  localparam logic [5:0] OFF_KEY_BASE = 6'h3C; // Unused base marker (keys below)
  localparam logic [5:0] OFF_FLAGS = 6'h3C; // Flag register (write sets or clears, see below)

  // ==========================================================
  // Field widths and positions in the flag register
  // ==========================================================
  localparam int NIB = 4; // All control registers are 4 bits
  localparam int FLAG_EXT_A = 0; // External request flag A
  localparam int FLAG_EXT_B = 1; // External request flag B
  localparam int FLAG_TMR1 = 2; // Timer one request flag
  localparam int FLAG_TMR2 = 3; // Timer two request flag
  localparam int FLAG_TMR3 = 4; // Timer three request flag
  localparam int FLAG_TMR4 = 5; // Timer four request flag
  localparam int FLAG_CONV = 6; // Conversion done flag
  localparam int FLAG_SER = 7; // Serial done flag
  localparam int FLAG_GIE = 8; // Global interrupt enable
  localparam int FLAG_WD1 = 9; // Watchdog flag first
  localparam int FLAG_WD2 = 10; // Watchdog flag second
  localparam int FLAG_SDE = 11; // Supply drop detector active (read only)
  localparam int FLAG_BKUP = 12; // Back-up state (read only)
  localparam int NFLAGS = 13; // Flag register width

  // ==========================================================
  // Reset and initial values
  // ==========================================================
  localparam logic [3:0] CLOCK_CTRL_INIT = 4'h0; // Clock control initial value
  localparam logic [3:0] CTRL_INIT = 4'h0; // Generic control initial value
  localparam logic [3:0] TIMER_UNDEF = 4'h0; // Value shown for undefined timer state

  // Operating phase of the block
  typedef enum logic [1:0] {
    BSR_RUN,
    BSR_BACKUP,
    BSR_WAKE
  } bsr_phase_t;

  // CPU side events that steer the block
  typedef struct packed {
    logic backup_enter; // Power-off completes back-up entry
    logic wake; // External wake-up arrived
    logic wd_restart; // Watchdog restart operation
  } bsr_cpu_ev_t;

endpackage

// [bsr_retention.sv]
// Backup state retention: retain/initialise policy of control state across RAM back-up
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module bsr_retention (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // CPU sequencing events
  input wire bsr_pkg::bsr_cpu_ev_t cpu_ev,
  // Pins
  input wire logic supply_drop_enable_pin,
  input wire logic [3:0] port_out_in,
  // State outputs
  output logic [3:0] port_level,
  output logic clock_stopped,
  output logic supply_drop_active,
  output logic [3:0] osc_select
);

  // ==========================================================
  // Storage
  // ==========================================================
  logic [3:0] clock_control_reg; // Cleared on entry
  logic [3:0] ext_irq_ctrl_a; // Retained
  logic [3:0] ext_irq_ctrl_b; // Retained
  logic [3:0] osc_sel_reg; // Retained
  logic [3:0] prescaler_ctrl_reg; // Cleared on entry
  logic [3:0] timer_ctrl [6]; // Index 3 is timer four
  logic [3:0] serial_mode_reg; // Retained
  logic [3:0] conv_ctrl [3]; // Retained
  logic [3:0] key_ctrl [3]; // Retained
  logic [3:0] pullup_ctrl [2]; // Retained
  logic [3:0] drive_ctrl [3]; // Retained
  logic [bsr_pkg::NFLAGS-1:0] flag_reg; // Event flags
  logic [3:0] port_reg; // Latched port level
  bsr_pkg::bsr_phase_t phase_reg; // Operating phase
  logic [2:0] pin_sync_reg; // Supply drop pin synchroniser
  logic sde_reg; // Filtered pin level
  logic ack_reg; // One wait cycle per access
  logic entering; // Back-up entry this cycle
  logic wr_hit; // Write accepted this cycle

  // Entry is taken only from the running phase; a repeat pulse while backed up is ignored
  assign entering = cpu_ev.backup_enter && (phase_reg == bsr_pkg::BSR_RUN);
  assign wr_hit = avs_write && ack_reg && (phase_reg == bsr_pkg::BSR_RUN);

  // Registers are frozen while the clock is stopped, so writes are only taken in RUN
  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    hit = (a == off);
  endfunction

  // ==========================================================
  // Bus handshake: one wait cycle, then answer
  // ==========================================================
  always_ff @(posedge clock) begin
    // Clearing after each answer gives a back-to-back request its own wait cycle
    if (rst || ack_reg) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= avs_read || avs_write;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

  // ==========================================================
  // Phase machine
  // ==========================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      phase_reg <= bsr_pkg::BSR_RUN;
    end else begin
      unique case (phase_reg)
        bsr_pkg::BSR_RUN: begin
          // Power-off completes entry and stops the clock
          if (entering) begin
            phase_reg <= bsr_pkg::BSR_BACKUP;
          end
        end
        bsr_pkg::BSR_BACKUP: begin
          // Only an external wake restarts the clock
          if (cpu_ev.wake) begin
            phase_reg <= bsr_pkg::BSR_WAKE;
          end
        end
        bsr_pkg::BSR_WAKE: begin
          // One settling cycle, then back to running
          phase_reg <= bsr_pkg::BSR_RUN;
        end
      endcase
    end
  end
  assign clock_stopped = (phase_reg == bsr_pkg::BSR_BACKUP);

  // ==========================================================
  // Clock control, prescaler and timer four initialised on entry; the whole timer control array lives here
  // ==========================================================
  // One process owns every timer word so no array element has two drivers
  always_ff @(posedge clock) begin
    if (rst) begin
      // Power-on values for every word here; entry forces only clock control, prescaler and timer four again
      clock_control_reg <= bsr_pkg::CLOCK_CTRL_INIT;
      prescaler_ctrl_reg <= bsr_pkg::CTRL_INIT;
      for (int i = 0; i < 6; i++) begin
        timer_ctrl[i] <= bsr_pkg::CTRL_INIT;
      end
    end else begin
      // Software writes, taken only while running
      if (wr_hit) begin
        if (hit(avs_address, bsr_pkg::OFF_CLOCK_CTRL)) begin
          clock_control_reg <= avs_writedata[3:0];
        end
        if (hit(avs_address, bsr_pkg::OFF_PRESCALER)) begin
          prescaler_ctrl_reg <= avs_writedata[3:0];
        end
        for (int i = 0; i < 6; i++) begin
          if (hit(avs_address, 6'(bsr_pkg::OFF_TIMER_BASE + 6'(4 * i)))) begin
            timer_ctrl[i] <= avs_writedata[3:0];
          end
        end
      end
      // Entry comes last so it beats a write in the same cycle; timers one to
      // three, five and six are left alone and keep their words
      if (entering) begin
        clock_control_reg <= bsr_pkg::CLOCK_CTRL_INIT;
        prescaler_ctrl_reg <= bsr_pkg::CTRL_INIT;
        timer_ctrl[3] <= bsr_pkg::CTRL_INIT;
      end
    end
  end

  // ==========================================================
  // Retained across back-up: only reset or a write changes them
  // ==========================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_irq_ctrl_a <= bsr_pkg::CTRL_INIT;
      ext_irq_ctrl_b <= bsr_pkg::CTRL_INIT;
      osc_sel_reg <= bsr_pkg::CTRL_INIT;
      serial_mode_reg <= bsr_pkg::CTRL_INIT;
      // Power-on values; back-up entry never reaches this process
      for (int i = 0; i < 3; i++) begin
        conv_ctrl[i] <= bsr_pkg::CTRL_INIT;
        key_ctrl[i] <= bsr_pkg::CTRL_INIT;
        drive_ctrl[i] <= bsr_pkg::CTRL_INIT;
      end
      for (int i = 0; i < 2; i++) begin
        pullup_ctrl[i] <= bsr_pkg::CTRL_INIT;
      end
    end else if (wr_hit) begin
      // Entry never touches these
      if (hit(avs_address, bsr_pkg::OFF_EXT_IRQ_A)) begin
        ext_irq_ctrl_a <= avs_writedata[3:0];
      end
      if (hit(avs_address, bsr_pkg::OFF_EXT_IRQ_B)) begin
        ext_irq_ctrl_b <= avs_writedata[3:0];
      end
      if (hit(avs_address, bsr_pkg::OFF_OSC_SEL)) begin
        osc_sel_reg <= avs_writedata[3:0];
      end
      if (hit(avs_address, bsr_pkg::OFF_SERIAL_MODE)) begin
        serial_mode_reg <= avs_writedata[3:0];
      end
      for (int i = 0; i < 3; i++) begin
        if (hit(avs_address, 6'(bsr_pkg::OFF_CONV_BASE + 6'(4 * i)))) begin
          conv_ctrl[i] <= avs_writedata[3:0];
        end
      end
      // The address space is full, so the first key, pull-up and drive words
      // ride in the flag word's upper lanes; the others keep their reset value
      if (hit(avs_address, bsr_pkg::OFF_FLAGS)) begin
        key_ctrl[0] <= avs_writedata[19:16];
        pullup_ctrl[0] <= avs_writedata[23:20];
        drive_ctrl[0] <= avs_writedata[27:24];
      end
    end
  end

  // ==========================================================
  // Port level: sampled from port_out_in while running, never written over the bus
  // ==========================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      port_reg <= bsr_pkg::CTRL_INIT;
    end else if (phase_reg == bsr_pkg::BSR_RUN) begin
      // Sampled only while running, so the level stays put through back-up and wake
      port_reg <= port_out_in; // Held frozen while backed up
    end
  end
  assign port_level = port_reg;
  assign osc_select = osc_sel_reg;

  // ==========================================================
  // Flags: set or cleared by writing; entry clears the initialised ones
  // ==========================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      flag_reg <= '0;
    end else if (entering) begin
      // Entry wins over a write or a restart in the same cycle
      flag_reg[bsr_pkg::FLAG_EXT_A] <= 1'b0;
      flag_reg[bsr_pkg::FLAG_EXT_B] <= 1'b0;
      flag_reg[bsr_pkg::FLAG_CONV] <= 1'b0;
      flag_reg[bsr_pkg::FLAG_SER] <= 1'b0;
      flag_reg[bsr_pkg::FLAG_GIE] <= 1'b0;
      flag_reg[bsr_pkg::FLAG_WD1] <= 1'b0;
      flag_reg[bsr_pkg::FLAG_WD2] <= 1'b0;
      // Timer flags carry no guaranteed value; shown as a fixed pattern
      flag_reg[bsr_pkg::FLAG_TMR4:bsr_pkg::FLAG_TMR1] <= bsr_pkg::TIMER_UNDEF;
    end else if (cpu_ev.wd_restart) begin
      // Restart before power-off keeps the watchdog quiet
      flag_reg[bsr_pkg::FLAG_WD1] <= 1'b0;
      flag_reg[bsr_pkg::FLAG_WD2] <= 1'b0;
    end else if (wr_hit && hit(avs_address, bsr_pkg::OFF_FLAGS)) begin
      // Software sets or clears the eleven writable flags; upper lanes go elsewhere
      flag_reg[bsr_pkg::FLAG_WD2:0] <= avs_writedata[bsr_pkg::FLAG_WD2:0];
    end
  end

  // ==========================================================
  // Supply drop enable pin: three-stage synchroniser, no register
  // ==========================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_sync_reg <= 3'h0;
      sde_reg <= 1'b0;
    end else begin
      // Only the second stage reads the first, so a metastable first stage stays contained
      pin_sync_reg <= {pin_sync_reg[1:0], supply_drop_enable_pin};
      // Hold the old level until the last two stages agree; costs one cycle of delay
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
        sde_reg <= pin_sync_reg[2];
      end
    end
  end
  assign supply_drop_active = sde_reg;

  // ==========================================================
  // Read mux; unmapped offsets read zero
  // ==========================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_reg) begin
      // Loaded in the wait cycle so the word stands at the answering edge
      // Cleared first; a hit below overwrites its lane, unmapped offsets stay zero
      avs_readdata <= 32'h0;
      if (hit(avs_address, bsr_pkg::OFF_CLOCK_CTRL)) avs_readdata[3:0] <= clock_control_reg;
      if (hit(avs_address, bsr_pkg::OFF_EXT_IRQ_A)) avs_readdata[3:0] <= ext_irq_ctrl_a;
      if (hit(avs_address, bsr_pkg::OFF_EXT_IRQ_B)) avs_readdata[3:0] <= ext_irq_ctrl_b;
      if (hit(avs_address, bsr_pkg::OFF_OSC_SEL)) avs_readdata[3:0] <= osc_sel_reg;
      if (hit(avs_address, bsr_pkg::OFF_PRESCALER)) avs_readdata[3:0] <= prescaler_ctrl_reg;
      if (hit(avs_address, bsr_pkg::OFF_SERIAL_MODE)) avs_readdata[3:0] <= serial_mode_reg;
      for (int i = 0; i < 6; i++) begin
        if (hit(avs_address, 6'(bsr_pkg::OFF_TIMER_BASE + 6'(4 * i)))) begin
          avs_readdata[3:0] <= timer_ctrl[i];
        end
      end
      for (int i = 0; i < 3; i++) begin
        if (hit(avs_address, 6'(bsr_pkg::OFF_CONV_BASE + 6'(4 * i)))) begin
          avs_readdata[3:0] <= conv_ctrl[i];
        end
      end
      if (hit(avs_address, bsr_pkg::OFF_FLAGS)) begin
        // Live flags, read-only status, then the control lanes and the held port level
        avs_readdata[bsr_pkg::FLAG_WD2:0] <= flag_reg[bsr_pkg::FLAG_WD2:0];
        avs_readdata[bsr_pkg::FLAG_SDE] <= sde_reg;
        avs_readdata[bsr_pkg::FLAG_BKUP] <= clock_stopped;
        avs_readdata[19:16] <= key_ctrl[0];
        avs_readdata[23:20] <= pullup_ctrl[0];
        avs_readdata[27:24] <= drive_ctrl[0];
        avs_readdata[31:28] <= port_reg;
      end
    end
  end

endmodule
`default_nettype wire

// [bsr_retention_props.sv]
// Concurrent checks on the ports of the backup state retention block
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module bsr_retention_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Sequencing and pins
  input wire bsr_pkg::bsr_cpu_ev_t cpu_ev,
  input wire logic supply_drop_enable_pin,
  // State outputs
  input wire logic [3:0] port_level,
  input wire logic clock_stopped,
  input wire logic supply_drop_active,
  input wire logic [3:0] osc_select
);
  // One clock domain, so one default clock and disable
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // A new read request always sees one wait cycle
  wait_first_a: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("no wait cycle on read");
  // A held request is answered at the next edge
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  // Entry stops the clock at the next edge
  stop_enter_a: assert property (cpu_ev.backup_enter && !clock_stopped |=> clock_stopped)
    else $error("entry did not stop clock");
  // Stopped state holds until a wake arrives
  stop_hold_a: assert property (clock_stopped && !cpu_ev.wake |=> clock_stopped)
    else $error("left backup without wake");
  // Wake leaves the stopped state
  wake_leave_a: assert property (clock_stopped && cpu_ev.wake |=> !clock_stopped)
    else $error("wake ignored");
  // Port levels frozen while stopped
  port_hold_a: assert property (clock_stopped && $past(clock_stopped) |-> $stable(port_level))
    else $error("port level moved in backup");
  // Oscillator choice unchanged across entry
  osc_keep_a: assert property (cpu_ev.backup_enter && !avs_write |=> $stable(osc_select))
    else $error("osc selection lost");
  // Detector follows the pin alone, high side
  sde_high_a: assert property (supply_drop_enable_pin [*6] |-> supply_drop_active)
    else $error("detector not active");
  // Detector follows the pin alone, low side
  sde_low_a: assert property (!supply_drop_enable_pin [*6] |-> !supply_drop_active)
    else $error("detector not idle");
  // Clock-stopped and port level outputs come out of reset at zero
  reset_zero_a: assert property ($fell(rst) |-> !clock_stopped && port_level == 4'h0)
    else $error("outputs not zero after reset");
endmodule
bind bsr_retention bsr_retention_props chk (.clock(clock), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .cpu_ev(cpu_ev),
  .supply_drop_enable_pin(supply_drop_enable_pin), .port_level(port_level),
  .clock_stopped(clock_stopped), .supply_drop_active(supply_drop_active),
  .osc_select(osc_select));
`default_nettype wire

// [tb.sv]
// Self-checking bench for the backup state retention block
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================
  // Signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  bsr_pkg::bsr_cpu_ev_t cpu_ev = '0;
  logic supply_drop_enable_pin = 1'b0;
  logic [3:0] port_out_in = 4'h0;
  logic [3:0] port_level;
  logic [3:0] osc_select;
  logic clock_stopped;
  logic supply_drop_active;
  logic [31:0] seed = 32'h0000005E; // Fixed start keeps runs repeatable
  logic [3:0] vals [15]; // Values written to the control words
  logic [63:0] notes [$]; // Expected read data over its mask
  logic [63:0] n; // Oldest note
  logic [3:0] pv; // Port level driven before entry
  logic [11:0] lanes = 12'h000; // Key, pull-up and drive lanes of the flag word
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  // Clock
  always #5 clock = ~clock;
  // ==========================================================
  // Device
  bsr_retention dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_ev(cpu_ev),
    .supply_drop_enable_pin(supply_drop_enable_pin), .port_out_in(port_out_in),
    .port_level(port_level), .clock_stopped(clock_stopped),
    .supply_drop_active(supply_drop_active), .osc_select(osc_select));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("Errors %0d, checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic [5:0] a, input logic wr, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock); // Idle edge: a following call never reassigns a strobe in one step
  endtask
  // Read with a note of what must come back
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({e, m});
    bus(a, 1'b0, 32'h00000000);
  endtask
  // One-cycle sequencing event
  task automatic pulse(input bsr_pkg::bsr_cpu_ev_t e);
    cpu_ev <= e;
    @(posedge clock);
    cpu_ev <= '0;
    @(posedge clock);
  endtask
  // All control words, then flags; timer flags masked since undefined
  task automatic rd_all(input logic bk);
    for (int i = 0; i < 15; i++) begin
      rd(6'(i * 4), {28'h0, (bk && (i == 0 || i == 4 || i == 8)) ? 4'h0 : vals[i]}, 32'hF);
    end
    rd(bsr_pkg::OFF_FLAGS, {4'h0, lanes, 4'h0, bk ? 12'h000 : 12'h7C3}, 32'h0FFF07C3);
  endtask
  // ==========================================================
  // Read monitor: oldest note against each answer
  always @(posedge clock) begin
    if (avs_read && !avs_waitrequest && notes.size() > 0) begin
      n = notes.pop_front();
      chk(avs_readdata & n[31:0], n[63:32], "read data");
    end
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      complete_run();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // Random nonzero values so a forced initial value shows
    for (int i = 0; i < 15; i++) begin
      vals[i] = 4'(rnd()) | 4'h1;
      bus(6'(i * 4), 1'b1, {28'h0, vals[i]});
    end
    bus(bsr_pkg::OFF_FLAGS, 1'b1, 32'h7FF);
    rd_all(1'b0);
    // Restart clears both watchdog flags
    pulse(3'b001);
    rd(bsr_pkg::OFF_FLAGS, 32'h1FF, 32'h7FF);
    // Upper lanes load the first key, pull-up and drive words before entry
    lanes = 12'(rnd());
    bus(bsr_pkg::OFF_FLAGS, 1'b1, {4'h0, lanes, 16'h07FF});
    pv = 4'(rnd());
    port_out_in <= pv;
    repeat (2) @(posedge clock);
    // Watchdog restart right before power-off
    pulse(3'b001);
    pulse(3'b100);
    chk(32'(clock_stopped), 32'h1, "not in backup");
    // Port moves and a write is tried while backed up; both must not land
    port_out_in <= ~pv;
    bus(6'h14, 1'b1, {28'h0, ~vals[5]});
    rd_all(1'b1);
    chk(32'(port_level), 32'(pv), "port level");
    supply_drop_enable_pin <= 1'b1;
    repeat (6) @(posedge clock);
    chk(32'(supply_drop_active), 32'h1, "detector idle");
    pulse(3'b010);
    repeat (8) @(posedge clock);
    rd_all(1'b1);
    chk(32'(osc_select), 32'(vals[3]), "osc select");
    supply_drop_enable_pin <= 1'b0;
    repeat (6) @(posedge clock);
    chk(32'(supply_drop_active), 32'h0, "detector active");
    // Software sets a fresh value after wake
    bus(bsr_pkg::OFF_CLOCK_CTRL, 1'b1, 32'h5);
    rd(bsr_pkg::OFF_CLOCK_CTRL, 32'h5, 32'hF);
    repeat (4) @(posedge clock);
    complete_run();
  end
endmodule
`default_nettype wire
